// file: inc/dhm_pkg.sv
// package: register map, field positions and bus carrier for the mailbox block
package dhm_pkg;
  // =====================================
  // register offsets
  localparam logic [7:0] DHM_OFS_MAILBOX_A = 8'h08;
  localparam logic [7:0] DHM_OFS_MAILBOX_B = 8'h09;
  localparam logic [7:0] DHM_OFS_MAILBOX_C = 8'h0a;
  localparam logic [7:0] DHM_OFS_FIRST = 8'h0b;
  localparam logic [7:0] DHM_OFS_SECOND_FLAG = 8'h20;
  localparam logic [7:0] DHM_OFS_SECOND_MASK = 8'h21;
  // =====================================
  // field positions and reset values
  localparam int DHM_MBOX_COUNT = 3;
  localparam int DHM_FLAG_TOP_BIT = 7;
  localparam int DHM_REV_BIT = 1;
  localparam logic [7:0] DHM_RST_BYTE = 8'h00;
  localparam logic DHM_RST_IRQ_N = 1'b1;
  // =====================================
  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dhm_req_s;
endpackage

// file: design/dhm_mailbox_slot.sv
// one mailbox: data byte plus its change flag
`timescale 1ns/1ps
module dhm_mailbox_slot
  import dhm_pkg::*;
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // register port, already decoded
  input wire logic i_wr_sel,
  input wire logic i_rd_sel,
  input wire logic [7:0] i_wdata,
  // state
  output logic [7:0] o_data,
  output logic o_flag
);
  import dhm_pkg::*;

  typedef struct packed {
    logic [7:0] data;
    logic flag;
  } dhm_slot_s;

  dhm_slot_s st;
  dhm_slot_s next_st;

  // =====================================
  // update
  always_comb begin
    next_st = st;
    if (i_wr_sel) begin
      next_st.data = i_wdata;
    end
    if (i_rd_sel) begin
      next_st.flag = 1'b0;
    end
    // only a real change of content raises the flag; set wins over clear
    if (i_wr_sel && (i_wdata != st.data)) begin
      next_st.flag = 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      st <= '{data: DHM_RST_BYTE, flag: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign o_data = st.data;
  assign o_flag = st.flag;

  // =====================================
  // checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_srst);

  AST_SLOT_SET: assert property (i_wr_sel && (i_wdata != o_data) |=> o_flag)
    else $error("mailbox flag not set on change");
  AST_SLOT_CLR: assert property (i_rd_sel && !i_wr_sel |=> !o_flag)
    else $error("mailbox flag not cleared on read");
  AST_SLOT_KEEP: assert property (!i_wr_sel |=> $stable(o_data))
    else $error("mailbox data changed without write");
endmodule

// file: design/dhm_mailbox_irq.sv
// mailbox register block: three mailboxes, two status/mask pairs, alert pin
`timescale 1ns/1ps
module dhm_mailbox_irq
  import dhm_pkg::*;
#(
  // 1 models the revision whose mailbox c bit 1 reads zero; value arbitrary
  parameter bit REV_MASKS_BIT1 = 1'b0
)(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // register port
  input wire dhm_pkg::dhm_req_s i_req,
  output logic [7:0] o_rdata,
  // first status sources from neighbour blocks: bit 4..1, levels
  input wire logic [4:1] i_first_src,
  // second status events from neighbour blocks, one-cycle pulses
  input wire logic [7:0] i_second_evt,
  // alert pin
  output logic o_irq_n
);
  import dhm_pkg::*;

  typedef struct packed {
    logic [7:0] first_mask;
    logic [7:0] second_flag;
    logic [7:0] second_mask;
    logic [7:0] rdata;
    logic irq_n;
  } dhm_state_s;

  dhm_state_s st;
  dhm_state_s next_st;

  logic [7:0] mb_data [DHM_MBOX_COUNT];
  logic [DHM_MBOX_COUNT-1:0] mb_flag;
  logic [7:0] first_status;
  logic [7:0] read_mux;
  logic [7:0] mb_c_view;

  // =====================================
  // mailboxes
  genvar gi;
  generate
    for (gi = 0; gi < DHM_MBOX_COUNT; gi++) begin : g_mbox
      dhm_mailbox_slot u_slot (
        .i_clock(i_clock),
        .i_srst(i_srst),
        .i_wr_sel(i_req.wr && (i_req.addr == DHM_OFS_MAILBOX_A + 8'(gi))),
        .i_rd_sel(i_req.rd && (i_req.addr == DHM_OFS_MAILBOX_A + 8'(gi))),
        .i_wdata(i_req.wdata),
        .o_data(mb_data[gi]),
        .o_flag(mb_flag[DHM_MBOX_COUNT-1-gi])
      );
    end
  endgenerate

  // =====================================
  // read view
  always_comb begin
    first_status = {mb_flag, i_first_src, 1'b0};
    mb_c_view = mb_data[2];
    if (REV_MASKS_BIT1) begin
      mb_c_view[DHM_REV_BIT] = 1'b0;
    end
    case (i_req.addr)
      DHM_OFS_MAILBOX_A: read_mux = mb_data[0];
      DHM_OFS_MAILBOX_B: read_mux = mb_data[1];
      DHM_OFS_MAILBOX_C: read_mux = mb_c_view;
      DHM_OFS_FIRST: read_mux = first_status;
      DHM_OFS_SECOND_FLAG: read_mux = st.second_flag;
      default: read_mux = DHM_RST_BYTE; // second mask is write-only and reads as zero, like unmapped offsets
    endcase
  end

  // =====================================
  // registers and alert pin
  always_comb begin
    next_st = st;
    if (i_req.rd) begin
      next_st.rdata = read_mux;
    end
    if (i_req.wr && (i_req.addr == DHM_OFS_FIRST)) begin
      next_st.first_mask = {i_req.wdata[7:1], 1'b0};
    end
    if (i_req.wr && (i_req.addr == DHM_OFS_SECOND_MASK)) begin
      next_st.second_mask = i_req.wdata;
    end
    if (i_req.wr && (i_req.addr == DHM_OFS_SECOND_FLAG)) begin
      next_st.second_flag = st.second_flag & ~i_req.wdata;
    end
    // an event in the clearing cycle is kept
    next_st.second_flag = next_st.second_flag | i_second_evt;
    // pin follows the masked sources one cycle later, glitch free
    next_st.irq_n = ~(|(first_status & st.first_mask) | |(st.second_flag & st.second_mask));
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      st <= '{first_mask: DHM_RST_BYTE, second_flag: DHM_RST_BYTE, second_mask: DHM_RST_BYTE,
              rdata: DHM_RST_BYTE, irq_n: DHM_RST_IRQ_N};
    end else begin
      st <= next_st;
    end
  end

  assign o_rdata = st.rdata;
  assign o_irq_n = st.irq_n;

  // =====================================
  // checks
  logic cause;
  assign cause = |(first_status & st.first_mask) | |(st.second_flag & st.second_mask);

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_srst);

  AST_IRQ_LOW: assert property (cause |=> !o_irq_n)
    else $error("alert pin not low with enabled flag");
  AST_IRQ_HIGH: assert property (!cause |=> o_irq_n)
    else $error("alert pin low without enabled flag");
  AST_MBA_PASS: assert property (i_req.wr && i_req.addr == DHM_OFS_MAILBOX_A ##1 i_req.rd &&
      i_req.addr == DHM_OFS_MAILBOX_A && !i_req.wr |=> o_rdata == $past(i_req.wdata, 2))
    else $error("mailbox a readback wrong");
  AST_MBB_WR: assert property (i_req.wr && i_req.addr == DHM_OFS_MAILBOX_B |=> mb_data[1] == $past(i_req.wdata))
    else $error("mailbox b not written");
  AST_FLAG_SET: assert property (i_req.wr && i_req.addr == DHM_OFS_MAILBOX_C && i_req.wdata != mb_data[2]
      |=> first_status[5] ##1 first_status[5] || $past(i_req.rd))
    else $error("mailbox c flag lost");
  AST_REV_BIT: assert property (i_req.rd && i_req.addr == DHM_OFS_MAILBOX_C |=>
      o_rdata[DHM_REV_BIT] == (REV_MASKS_BIT1 ? 1'b0 : mb_data[2][DHM_REV_BIT]))
    else $error("mailbox c bit 1 readback wrong");
  AST_ST2_CLR: assert property (i_req.wr && i_req.addr == DHM_OFS_SECOND_FLAG && i_req.wdata[7] && !i_second_evt[7]
      |=> !st.second_flag[7])
    else $error("second flag not cleared");
  AST_ST2_SET: assert property (i_second_evt[0] |=> st.second_flag[0] ##1 st.second_flag[0] || $past(i_req.wr))
    else $error("second flag event lost");
  AST_MASK2: assert property (i_req.wr && i_req.addr == DHM_OFS_SECOND_MASK |=> st.second_mask == $past(i_req.wdata))
    else $error("second mask not written");
  AST_FIRST_RD: assert property (i_req.rd && i_req.addr == DHM_OFS_FIRST |=> o_rdata == $past(first_status))
    else $error("first status readback wrong");
  // looks one edge ahead so the very first tick never meets unreset state
  AST_RESET: assert property (@(posedge i_clock) disable iff (1'b0) i_srst |=> o_irq_n &&
      st.first_mask == 8'h00 && st.second_mask == 8'h00)
    else $error("masks or pin wrong after reset");

  COV_IRQ: cover property (o_irq_n ##1 !o_irq_n);
  COV_MSG: cover property (i_req.wr && i_req.addr == DHM_OFS_MAILBOX_A ##[1:20] i_req.rd && i_req.addr == DHM_OFS_MAILBOX_A);
  COV_W1C: cover property (st.second_flag != 8'h00 ##1 i_req.wr && i_req.addr == DHM_OFS_SECOND_FLAG);
  COV_RACE: cover property (i_second_evt[3] && i_req.wr && i_req.addr == DHM_OFS_SECOND_FLAG && i_req.wdata[3]);
endmodule

// file: tb/dhm_host_model.sv
// host model: the single controller driving the register port
`timescale 1ns/1ps
module dhm_host_model (
  // clock
  input wire logic i_clock,
  // register port request
  output dhm_pkg::dhm_req_s o_req
);
  import dhm_pkg::*;
  // =====================================
  // expected read data, oldest first
  logic [7:0] exp_q[$];
  initial o_req = '0;
  // idle cycle after each strobe so two strobes never merge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    o_req <= '{1'b1, 1'b0, a, d};
    @(posedge i_clock);
    o_req <= '0;
    @(posedge i_clock);
  endtask
  // write then read of one offset on back-to-back edges, the tightest legal order
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
    exp_q.push_back(d);
    o_req <= '{1'b1, 1'b0, a, d};
    @(posedge i_clock);
    o_req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge i_clock);
    o_req <= '0;
    @(posedge i_clock);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    o_req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge i_clock);
    o_req <= '0;
    @(posedge i_clock);
  endtask
endmodule

// file: tb/tb.sv
// testbench for the mailbox register block
`timescale 1ns/1ps
module tb;
  import dhm_pkg::*;
  logic i_clock, i_srst, o_irq_n, rd_d;
  dhm_req_s req;
  logic [7:0] o_rdata, rev_rdata, v, evt;
  logic [4:1] src;
  logic [2:0] idx;
  int n_fail, samples_checked, cycles, seed;
  dhm_host_model dhm_host_model_inst (.i_clock(i_clock), .o_req(req));
  dhm_mailbox_irq dhm_mailbox_irq_inst (.i_clock(i_clock), .i_srst(i_srst), .i_req(req), .o_rdata(o_rdata),
    .i_first_src(src), .i_second_evt(evt), .o_irq_n(o_irq_n));
  // second copy built as the revision whose mailbox c bit 1 reads zero
  dhm_mailbox_irq #(.REV_MASKS_BIT1(1'b1)) dhm_mailbox_irq_rev_inst (.i_clock(i_clock), .i_srst(i_srst),
    .i_req(req), .o_rdata(rev_rdata), .i_first_src(src), .i_second_evt(evt), .o_irq_n());
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  // =====================================
  // compare and report
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // pin is registered behind the flags, so allow two edges
  task automatic pin(input logic e);
    repeat (2) @(posedge i_clock);
    @(negedge i_clock);
    check({7'h00, o_irq_n}, {7'h00, e});
  endtask
  // =====================================
  // read data monitor and hang limit
  always @(posedge i_clock) begin
    rd_d <= req.rd;
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_fail++;
      give_verdict();
    end
  end
  always @(negedge i_clock) begin
    if (rd_d === 1'b1) check(o_rdata, dhm_host_model_inst.exp_q.pop_front());
  end
  // =====================================
  // main sequence
  initial begin
    seed = 32'h757590b5;
    n_fail = 0;
    samples_checked = 0;
    cycles = 0;
    rd_d = 1'b0;
    i_srst = 1'b1;
    src = 4'h0;
    evt = 8'h00;
    repeat (10) @(posedge i_clock);
    i_srst <= 1'b0;
    src <= 4'($random(seed));
    @(posedge i_clock);
    dhm_host_model_inst.rd(DHM_OFS_FIRST, {3'b000, src, 1'b0});
    pin(1'b1);
    $display("reset test done");
    // bit 1 forced so its readback is seen
    for (int k = 0; k < 3; k++) begin
      v = 8'($random(seed)) | 8'h02;
      dhm_host_model_inst.wr(DHM_OFS_MAILBOX_A + 8'(k), v);
      dhm_host_model_inst.rd(DHM_OFS_FIRST, (8'h80 >> k) | {3'b000, src, 1'b0});
      dhm_host_model_inst.rd(DHM_OFS_MAILBOX_A + 8'(k), v);
      if (k == 2) check(rev_rdata, v & ~8'h02);
      dhm_host_model_inst.rd(DHM_OFS_FIRST, {3'b000, src, 1'b0});
    end
    dhm_host_model_inst.wr_rd(DHM_OFS_MAILBOX_A, ~v);
    $display("mailbox test done");
    dhm_host_model_inst.wr(DHM_OFS_FIRST, 8'he0);
    dhm_host_model_inst.rd(DHM_OFS_FIRST, {3'b000, src, 1'b0});
    dhm_host_model_inst.wr(DHM_OFS_MAILBOX_C, ~v);
    pin(1'b0);
    dhm_host_model_inst.rd(DHM_OFS_MAILBOX_C, ~v);
    pin(1'b1);
    $display("first alert test done");
    dhm_host_model_inst.wr(DHM_OFS_FIRST, 8'h00);
    idx = 3'($random(seed));
    dhm_host_model_inst.wr(DHM_OFS_SECOND_MASK, 8'h01 << idx);
    evt <= 8'h01 << idx;
    @(posedge i_clock);
    evt <= 8'h00;
    pin(1'b0);
    dhm_host_model_inst.rd(DHM_OFS_SECOND_FLAG, 8'h01 << idx);
    dhm_host_model_inst.rd(DHM_OFS_SECOND_MASK, 8'h00);
    dhm_host_model_inst.rd(8'h40, 8'h00);
    dhm_host_model_inst.wr(DHM_OFS_SECOND_FLAG, 8'h01 << idx);
    pin(1'b1);
    dhm_host_model_inst.rd(DHM_OFS_SECOND_FLAG, 8'h00);
    $display("second alert test done");
    repeat (2) @(posedge i_clock);
    give_verdict();
  end
endmodule
